// ===== wdog_pkg.sv
// Register map, key codes, timing and state type of the watchdog block
package wdog_pkg;
  localparam int CLK_MHZ             = 250;
  // Soft reset delay in ns; no figure is given, so this is a plain default
  localparam int SOFT_RESET_DELAY_NS = 1000;
  localparam int SOFT_RESET_CYC      = (SOFT_RESET_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int ADDR_W              = 12;
  localparam int CNT_W               = 18;
  localparam int PORT_A_W            = 8;

  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RST_REG_SOFT_RESET_FLAG   = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_CLK    = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_WAKE   = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_COUNT  = 12'h014;

  localparam logic [7:0] CTRL_RESET  = 8'h53;
  localparam int         KEY_MSB     = 7;
  localparam int         KEY_LSB     = 3;
  localparam int         SEL_MSB     = 2;
  localparam logic [4:0] KEY_ENABLE  = 5'h0A;
  localparam logic [4:0] KEY_DISABLE = 5'h15;

  localparam int KEY_FLAG_BIT  = 0;
  localparam int LO_KEEP_BIT   = 0;
  localparam int HI_KEEP_BIT   = 1;
  localparam int STAT_TO_BIT   = 0;
  localparam int STAT_PDF_BIT  = 1;
  localparam int STAT_HALT_BIT = 2;

  typedef enum logic [1:0] {
    ST_RUN      = 2'b00,
    ST_HALTED   = 2'b01,
    ST_KEY_WAIT = 2'b10
  } state_type;

  // Last count before overflow for each period select code
  function automatic logic [CNT_W-1:0] period_last(input logic [2:0] sel);
    case (sel)
      3'h0:    period_last = 18'h0_00FF;
      3'h1:    period_last = 18'h0_03FF;
      3'h2:    period_last = 18'h0_0FFF;
      3'h3:    period_last = 18'h0_3FFF;
      3'h4:    period_last = 18'h0_7FFF;
      3'h5:    period_last = 18'h0_FFFF;
      3'h6:    period_last = 18'h1_FFFF;
      default: period_last = 18'h3_FFFF;
    endcase
  endfunction
endpackage

// ===== pin_edge_sync.sv
// Two-flop synchroniser with rise and fall pulses for a group of pins
`timescale 1ns/100ps
module pin_edge_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output wire logic [W-1:0] rise,
  output wire logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // Only sync_q reads meta_q; edges are taken between later stages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule

// ===== wdog_powerdown_wake_ctrl.sv
// Watchdog, power-down entry and wake-up control with an APB register file
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
// How it works
// - Halt with fast keep set, slow keep clear: fast clock on, slow off, CPU stalled.
// - Halt sets the power-down flag and clears the time-out flag.
// - Halt clears the counter; it counts on only while the watchdog is enabled.
// - While halted, memory, registers and port states are held.
// - Wake from halt on enabled port A fall, new interrupt, or overflow.
// - Power-down flag clears at power-up and on the clear-watchdog instruction.
// - Overflow while halted sets time-out and resets only PC and stack pointer.
// - Each port A pin has a wake mask bit; such a wake resumes after halt.
// - Disabled interrupt or full stack: resume after halt, keep interrupt deferred.
// - Enabled interrupt with stack room: normal interrupt service on wake.
// - An interrupt already requested before halt does not wake.
// - Counter runs on slow RC clock, divided by 2^8 up to 2^18.
// - Period codes 000 to 111 give 2^8,10,12,14,15,16,17,18 periods.
// - Key 10101B disables, 01010B enables, others reset after the soft delay.
// - A key reset sets the key reset flag, bit 0 of the reset flags.
// - Hardware never clears the key reset flag; software writes zero to clear.
// - Key field powers up enabled and period select at 011.
// - Overflow in normal running gives a full reset and sets time-out.
// - Counter clears on key reset, clear-watchdog, halt, overflow, and while the watchdog is disabled.
module wdog_powerdown_wake_ctrl #(
  parameter int PA_W       = wdog_pkg::PORT_A_W,
  parameter int SRESET_CYC = wdog_pkg::SOFT_RESET_CYC
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [wdog_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output wire logic                        pready,
  output wire logic                        pslverr,
  input  wire logic                        slow_rc_clock,
  input  wire logic [PA_W-1:0]             port_a_pin,
  input  wire logic                        halt_instr,
  input  wire logic                        clear_wdog_instr,
  input  wire logic                        irq_request,
  input  wire logic                        irq_enabled,
  input  wire logic                        stack_full,
  output wire logic                        cpu_stalled,
  output wire logic                        io_hold,
  output wire logic                        fast_clk_en,
  output wire logic                        slow_clk_en,
  output wire logic                        wdog_enabled,
  output logic                             device_reset,
  output logic                             pc_sp_reset,
  output logic                             wake_resume,
  output logic                             wake_irq_service,
  output logic                             irq_deferred
);
  localparam int DLY_W = $clog2(SRESET_CYC + 1);

  wdog_pkg::state_type     state_q;
  wdog_pkg::state_type     state_d;
  logic [7:0]              ctrl_q;
  logic [7:0]              ctrl_d;
  logic                    hi_keep_q;
  logic                    lo_keep_q;
  logic [PA_W-1:0]         wake_mask_q;
  logic                    key_flag_q;
  logic                    key_flag_d;
  logic                    pdf_q;
  logic                    pdf_d;
  logic                    to_q;
  logic                    to_d;
  logic [wdog_pkg::CNT_W-1:0] cnt_q;
  logic [wdog_pkg::CNT_W-1:0] cnt_d;
  logic [DLY_W-1:0]        dly_q;
  logic                    irq_pre_q;
  logic                    irq_pre_d;
  logic                    irq_def_d;
  logic [7:0]              rst_reg_soft_reset_flag_byte;
  logic [7:0]              clk_byte;
  logic [7:0]              stat_byte;
  logic [31:0]             rd_word;
  logic                    slow_tick;
  logic [PA_W-1:0]         pa_fall;

  pin_edge_sync #(.W(1)) u_slow_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (slow_rc_clock),
    .rise  (slow_tick),
    .fall  ()
  );

  pin_edge_sync #(.W(PA_W)) u_port_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (port_a_pin),
    .rise  (),
    .fall  (pa_fall)
  );

  // Bus decode; zero wait states, unmapped addresses answer with an error
  wire sel_ctrl   = paddr == wdog_pkg::ADDR_CTRL;
  wire sel_rst_reg_soft_reset_flag   = paddr == wdog_pkg::ADDR_RST_REG_SOFT_RESET_FLAG;
  wire sel_clk    = paddr == wdog_pkg::ADDR_CLK;
  wire sel_wake   = paddr == wdog_pkg::ADDR_WAKE;
  wire sel_status = paddr == wdog_pkg::ADDR_STATUS;
  wire sel_count  = paddr == wdog_pkg::ADDR_COUNT;
  wire mapped     = sel_ctrl | sel_rst_reg_soft_reset_flag | sel_clk | sel_wake | sel_status | sel_count;
  wire access     = psel & penable;
  wire wr_ok      = access & pwrite & mapped;
  wire setup_rd   = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = access & ~mapped;

  wire halted      = state_q == wdog_pkg::ST_HALTED;
  wire running     = state_q == wdog_pkg::ST_RUN;
  wire [4:0] key   = ctrl_q[wdog_pkg::KEY_MSB:wdog_pkg::KEY_LSB];
  wire [2:0] p_sel = ctrl_q[wdog_pkg::SEL_MSB:0];
  assign wdog_enabled = key == wdog_pkg::KEY_ENABLE;
  wire key_bad     = !wdog_enabled && key != wdog_pkg::KEY_DISABLE;
  wire halt_go     = running & halt_instr;
  wire clear_go    = running & clear_wdog_instr;
  wire key_fire    = state_q == wdog_pkg::ST_KEY_WAIT && dly_q == '0;

  assign fast_clk_en = !halted | hi_keep_q;
  // Slow clock also survives halt for an enabled watchdog unless fast keep is set
  assign slow_clk_en = !halted | lo_keep_q | (wdog_enabled & ~hi_keep_q);
  assign cpu_stalled = halted;
  assign io_hold     = halted;

  wire cnt_run = wdog_enabled & slow_tick & slow_clk_en;
  wire ovf     = cnt_run && cnt_q == wdog_pkg::period_last(p_sel);

  wire pa_wake = |(pa_fall & wake_mask_q);
  wire irq_new = irq_request & ~irq_pre_q;
  wire irq_ok  = irq_enabled & ~stack_full;

  assign cnt_d = (halt_go | clear_go | key_fire | ovf | !wdog_enabled) ? '0
               : cnt_run ? cnt_q + 1'b1 : cnt_q;

  assign pdf_d = halt_go ? 1'b1 : clear_go ? 1'b0 : pdf_q;
  // time-out set, set wins over halt clear
  assign to_d  = ovf ? 1'b1 : halt_go ? 1'b0 : to_q;

  assign key_flag_d = key_fire ? 1'b1
                    : (wr_ok && sel_rst_reg_soft_reset_flag && !pwdata[wdog_pkg::KEY_FLAG_BIT]) ? 1'b0
                    : key_flag_q;

  // Request level seen at halt entry stays masked until it drops
  assign irq_pre_d = halt_go ? irq_request : (irq_pre_q & irq_request);
  assign irq_def_d = (halted && !ovf && irq_new && !irq_ok) ? 1'b1
                   : irq_ok ? 1'b0 : irq_deferred;

  // Key reset restores the control register; other writes store as given
  assign ctrl_d = key_fire ? wdog_pkg::CTRL_RESET
                : (wr_ok && sel_ctrl) ? pwdata[7:0] : ctrl_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      wdog_pkg::ST_RUN:
      begin
        if (key_bad)
          state_d = wdog_pkg::ST_KEY_WAIT;
        else if (halt_go)
          state_d = wdog_pkg::ST_HALTED;
      end
      wdog_pkg::ST_HALTED:
      begin
        if (ovf | irq_new | pa_wake)
          state_d = wdog_pkg::ST_RUN;
      end
      wdog_pkg::ST_KEY_WAIT:
      begin
        if (key_fire)
          state_d = wdog_pkg::ST_RUN;
      end
      default: state_d = wdog_pkg::ST_RUN;
    endcase
  end

  assign rst_reg_soft_reset_flag_byte = 8'(key_flag_q) << wdog_pkg::KEY_FLAG_BIT;
  assign clk_byte  = (8'(hi_keep_q) << wdog_pkg::HI_KEEP_BIT)
                   | (8'(lo_keep_q) << wdog_pkg::LO_KEEP_BIT);
  assign stat_byte = (8'(to_q) << wdog_pkg::STAT_TO_BIT)
                   | (8'(pdf_q) << wdog_pkg::STAT_PDF_BIT)
                   | (8'(halted) << wdog_pkg::STAT_HALT_BIT);
  assign rd_word   = sel_ctrl   ? 32'(ctrl_q)
                   : sel_rst_reg_soft_reset_flag   ? 32'(rst_reg_soft_reset_flag_byte)
                   : sel_clk    ? 32'(clk_byte)
                   : sel_wake   ? 32'(wake_mask_q)
                   : sel_status ? 32'(stat_byte)
                   : sel_count  ? 32'(cnt_q)
                   : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= wdog_pkg::ST_RUN;
      ctrl_q  <= wdog_pkg::CTRL_RESET;
      cnt_q   <= '0;
      dly_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      ctrl_q  <= ctrl_d;
      cnt_q   <= cnt_d;
      dly_q   <= (running && key_bad) ? DLY_W'(SRESET_CYC - 1)
               : (dly_q != '0) ? dly_q - 1'b1 : dly_q;
    end
  end

  // Flags; power-up clears both status flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pdf_q        <= 1'b0;
      to_q         <= 1'b0;
      key_flag_q   <= 1'b0;
      irq_pre_q    <= 1'b0;
      irq_deferred <= 1'b0;
    end
    else
    begin
      pdf_q        <= pdf_d;
      to_q         <= to_d;
      key_flag_q   <= key_flag_d;
      irq_pre_q    <= irq_pre_d;
      irq_deferred <= irq_def_d;
    end
  end

  // wake mask and oscillator keep bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_mask_q <= '0;
      hi_keep_q   <= 1'b0;
      lo_keep_q   <= 1'b0;
      prdata      <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ok && sel_wake)
        wake_mask_q <= pwdata[PA_W-1:0];
      if (wr_ok && sel_clk)
      begin
        hi_keep_q <= pwdata[wdog_pkg::HI_KEEP_BIT];
        lo_keep_q <= pwdata[wdog_pkg::LO_KEEP_BIT];
      end
      // Read data is captured in the setup cycle so it comes from a flop
      if (setup_rd)
        prdata <= rd_word;
    end
  end

  // One-cycle pulses to the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      device_reset     <= 1'b0;
      pc_sp_reset      <= 1'b0;
      wake_resume      <= 1'b0;
      wake_irq_service <= 1'b0;
    end
    else
    begin
      // full reset on normal overflow or key reset
      device_reset     <= (running & ovf) | key_fire;
      pc_sp_reset      <= halted & ovf;
      wake_resume      <= halted & ~ovf & ((irq_new & ~irq_ok) | (~irq_new & pa_wake));
      wake_irq_service <= halted & ~ovf & irq_new & irq_ok;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence halt_entry;
    halt_go ##1 halted;
  endsequence

  chk_halt_flags: assert property (halt_go && !ovf |=> pdf_q && !to_q && cnt_q == '0)
    else $error("halt did not set pdf, clear to and clear the counter");
  chk_halt_counter: assert property (halt_entry ##0 !wdog_enabled |-> cnt_q == '0)
    else $error("disabled watchdog counted in halt");
  chk_idle_fast_osc: assert property (halt_entry ##0 hi_keep_q && !lo_keep_q
    |-> fast_clk_en && !slow_clk_en && cpu_stalled)
    else $error("fast-oscillator idle clocks wrong");
  chk_clear_pdf: assert property (clear_go && !halt_go |=> !pdf_q)
    else $error("clear-watchdog left pdf set");
  chk_halt_tmo: assert property (halted && ovf |=> to_q && pc_sp_reset && !device_reset && running)
    else $error("halted overflow did not do a partial reset");
  chk_run_tmo: assert property (running && ovf |=> device_reset && to_q)
    else $error("running overflow did not reset");
  chk_key_wait: assert property ($rose(state_q == wdog_pkg::ST_KEY_WAIT)
    |-> (!device_reset)[*8])
    else $error("key reset fired too early");
  chk_key_flag: assert property (key_fire |=> key_flag_q && device_reset && ctrl_q == wdog_pkg::CTRL_RESET)
    else $error("key reset did not set its flag");
  chk_flag_sticky: assert property (key_flag_q && !(wr_ok && sel_rst_reg_soft_reset_flag) |=> key_flag_q)
    else $error("key reset flag cleared by hardware");
  chk_cnt_disabled: assert property (!wdog_enabled |=> cnt_q == '0)
    else $error("counter moved while disabled");
  chk_port_wake: assert property (halted && pa_wake && !irq_new && !ovf |=> wake_resume && running)
    else $error("port wake did not resume");
  chk_stale_irq: assert property (halted && irq_request && irq_pre_q && !pa_wake && !ovf |=> halted)
    else $error("stale interrupt woke the device");
  chk_halt_count: assert property (halted && cnt_run && !ovf
    |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("enabled watchdog stopped counting in halt");
  chk_irq_service: assert property (halted && irq_new && irq_ok && !ovf
    |=> wake_irq_service && running && !irq_deferred)
    else $error("enabled interrupt wake was not serviced");
  chk_irq_defer: assert property (halted && irq_new && !irq_ok && !ovf
    |=> wake_resume && irq_deferred && running)
    else $error("blocked interrupt wake was not deferred");
endmodule

// ===== wdog_powerdown_wake_ctrl_tb.sv
// Self-checking testbench for the watchdog, power-down and wake control block
`timescale 1ns/100ps
module wdog_powerdown_wake_ctrl_tb;
  localparam int SRC = 12;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slow_rc_clock;
  logic [7:0]  port_a_pin;
  logic        halt_instr;
  logic        clear_wdog_instr;
  logic        irq_request;
  logic        irq_enabled;
  logic        stack_full;
  logic        cpu_stalled;
  logic        io_hold;
  logic        fast_clk_en;
  logic        slow_clk_en;
  logic        wdog_enabled;
  logic        device_reset;
  logic        pc_sp_reset;
  logic        wake_resume;
  logic        wake_irq_service;
  logic        irq_deferred;
  logic        slow_run;
  logic [1:0]  div_q;
  int          fails;
  int          n_compared;

  wdog_powerdown_wake_ctrl #(.PA_W(8), .SRESET_CYC(SRC)) dut_u (.*);

  initial
  begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {slow_rc_clock, halt_instr, clear_wdog_instr, irq_request} = '0;
    {irq_enabled, stack_full, slow_run, div_q} = '0;
    port_a_pin = 8'hFF;
    fails = 0;
    n_compared = 0;
  end

  always #2 pclk = ~pclk;

  // Slow clock stands still unless a test lets it run; rising edge every 4 cycles
  always @(posedge pclk)
  begin
    div_q <= div_q + 2'h1;
    if (slow_run)
      slow_rc_clock <= div_q[1];
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench watchdog ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, exp, q);
  endtask

  // Core instruction pulse: 0 halt, 1 clear-watchdog
  task automatic cmd(input int s);
    @(posedge pclk);
    if (s == 0)
      halt_instr <= 1'b1;
    else
      clear_wdog_instr <= 1'b1;
    @(posedge pclk);
    halt_instr <= 1'b0;
    clear_wdog_instr <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0:       pick = wake_resume;
      1:       pick = wake_irq_service;
      2:       pick = pc_sp_reset;
      default: pick = device_reset;
    endcase
  endfunction

  task automatic wait_out(input int s, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pick(s) !== 1'b1 && n < lim);
    chk("pulse_seen", 32'h0000_0001, {31'h0, pick(s)});
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd("ctrl_por", wdog_pkg::ADDR_CTRL, 32'h0000_0053);
    rd("rst_reg_soft_reset_flag_por", wdog_pkg::ADDR_RST_REG_SOFT_RESET_FLAG, 32'h0000_0000);
    rd("stat_por", wdog_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("enabled_por", 32'h0000_0001, {31'h0, wdog_enabled});
    apb(1'b0, 12'h020, 32'h0000_0000, q, e);
    chk("unmapped_err", 32'h0000_0001, {31'h0, e});
    chk("unmapped_data", 32'h0000_0000, q);
    $display("test reset done");
  endtask

  task automatic t_idle_fast_osc_mode_port();
    int n;
    wr(wdog_pkg::ADDR_CLK, 32'h0000_0002);
    wr(wdog_pkg::ADDR_WAKE, 32'h0000_0001);
    cmd(0);
    chk("stall", 32'h0000_0001, {31'h0, cpu_stalled});
    chk("fast_on", 32'h0000_0001, {31'h0, fast_clk_en});
    chk("slow_off", 32'h0000_0000, {31'h0, slow_clk_en});
    chk("io_hold", 32'h0000_0001, {31'h0, io_hold});
    rd("stat_halt", wdog_pkg::ADDR_STATUS, 32'h0000_0006);
    rd("count_halt", wdog_pkg::ADDR_COUNT, 32'h0000_0000);
    rd("clk_kept", wdog_pkg::ADDR_CLK, 32'h0000_0002);
    port_a_pin[1] <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("masked_pin", 32'h0000_0001, {31'h0, cpu_stalled});
    port_a_pin[0] <= 1'b0;
    wait_out(0, 8, n);
    chk("resumed", 32'h0000_0000, {31'h0, cpu_stalled});
    port_a_pin <= 8'hFF;
    cmd(1);
    rd("pdf_cleared", wdog_pkg::ADDR_STATUS, 32'h0000_0000);
    $display("test idle_fast_osc_mode and port wake done");
  endtask

  task automatic t_irq(input logic en, input logic full);
    int n;
    irq_enabled <= en;
    stack_full <= full;
    cmd(0);
    irq_request <= 1'b1;
    wait_out((en && !full) ? 1 : 0, 8, n);
    chk("deferred", {31'h0, !(en && !full)}, {31'h0, irq_deferred});
    irq_enabled <= 1'b1;
    stack_full <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("deferred_gone", 32'h0000_0000, {31'h0, irq_deferred});
    irq_request <= 1'b0;
    repeat (2) @(posedge pclk);
    $display("test interrupt wake done");
  endtask

  task automatic t_stale();
    int n;
    irq_enabled <= 1'b1;
    irq_request <= 1'b1;
    cmd(0);
    repeat (10) @(posedge pclk);
    chk("stale_no_wake", 32'h0000_0001, {31'h0, cpu_stalled});
    irq_request <= 1'b0;
    @(posedge pclk);
    irq_request <= 1'b1;
    wait_out(1, 8, n);
    irq_request <= 1'b0;
    $display("test stale interrupt done");
  endtask

  task automatic t_run_ovf(input logic [2:0] sel, input int exp);
    int n;
    wr(wdog_pkg::ADDR_CTRL, {24'h0, 5'h0A, sel});
    cmd(1);
    slow_run <= 1'b1;
    wait_out(3, exp + 40, n);
    chk("ovf_time", 32'h0000_0001, {31'h0, n >= exp - 8 && n <= exp + 12});
    slow_run <= 1'b0;
    rd("stat_to", wdog_pkg::ADDR_STATUS, 32'h0000_0001);
    $display("test running overflow done");
  endtask

  task automatic t_halt_ovf();
    int n;
    wr(wdog_pkg::ADDR_CLK, 32'h0000_0000);
    wr(wdog_pkg::ADDR_CTRL, 32'h0000_0050);
    cmd(0);
    chk("sleep_slow_on", 32'h0000_0001, {31'h0, slow_clk_en});
    slow_run <= 1'b1;
    wait_out(2, 1100, n);
    chk("no_full_reset", 32'h0000_0000, {31'h0, device_reset});
    slow_run <= 1'b0;
    rd("stat_to_pdf", wdog_pkg::ADDR_STATUS, 32'h0000_0003);
    cmd(1);
    $display("test halted overflow done");
  endtask

  task automatic t_key();
    int n;
    wr(wdog_pkg::ADDR_CTRL, 32'h0000_00A8);
    @(posedge pclk);
    chk("disabled", 32'h0000_0000, {31'h0, wdog_enabled});
    cmd(1);
    slow_run <= 1'b1;
    repeat (200) @(posedge pclk);
    slow_run <= 1'b0;
    rd("count_held", wdog_pkg::ADDR_COUNT, 32'h0000_0000);
    wr(wdog_pkg::ADDR_CTRL, 32'h0000_0050);
    @(posedge pclk);
    chk("reenabled", 32'h0000_0001, {31'h0, wdog_enabled});
    wr(wdog_pkg::ADDR_CTRL, 32'h0000_0000);
    wait_out(3, SRC + 4, n);
    rd("ctrl_restored", wdog_pkg::ADDR_CTRL, 32'h0000_0053);
    rd("key_flag", wdog_pkg::ADDR_RST_REG_SOFT_RESET_FLAG, 32'h0000_0001);
    wr(wdog_pkg::ADDR_RST_REG_SOFT_RESET_FLAG, 32'h0000_0001);
    rd("flag_kept", wdog_pkg::ADDR_RST_REG_SOFT_RESET_FLAG, 32'h0000_0001);
    wr(wdog_pkg::ADDR_RST_REG_SOFT_RESET_FLAG, 32'h0000_0000);
    rd("flag_cleared", wdog_pkg::ADDR_RST_REG_SOFT_RESET_FLAG, 32'h0000_0000);
    $display("test key field done");
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_idle_fast_osc_mode_port();
    t_irq(1'b1, 1'b0);
    t_irq(1'b0, 1'b0);
    t_irq(1'b1, 1'b1);
    t_stale();
    t_run_ovf(3'h0, 1024);
    t_run_ovf(3'h1, 4096);
    t_run_ovf(3'h2, 16384);
    t_halt_ovf();
    t_key();
    close_out();
  end

  // Runs take under 25000 cycles; the limit leaves ample slack
  initial
  begin
    repeat (60000) @(posedge pclk);
    fails++;
    close_out();
  end
endmodule
